// ---- prio_trap_defines.vh ----
// register offsets, field positions, reset values for the priority and trap block
// assumes inclusion by bare name from the design files
`ifndef PRIO_TRAP_DEFINES_VH
`define PRIO_TRAP_DEFINES_VH
`define OFF_STATUS_WORD 12'h000
`define OFF_CORE_CTRL 12'h004
`define OFF_TRAP_CTRL 12'h008
`define OFF_IRQ_STATUS 12'h00c
`define OFF_IRQ_MASK 12'h010
`define OFF_TRAP_STIM 12'h014
`define LVL_HI 7
`define LVL_LO 5
`define LVL_MAX 3'h7
`define MSB_BIT 3
`define NEST_BIT 15
`define DIV0_BIT 6
`define MATH_BIT 4
`define ADDR_BIT 3
`define STK_BIT 2
`define OSC_BIT 1
`define TRAP_MASK 16'h005e
`define TRAP_RESET 16'h0000
`define EVT_W 5
`endif

// ---- trap_flag_bit.v ----
// one sticky trap flag: hardware set, software write-zero clear
// assumes pclk domain inputs
`timescale 1ns/10ps
`include "prio_trap_defines.vh"
module trap_flag_bit (
	input wire pclk,
	input wire presetn,
	input wire set_evt,
	input wire clr,
	output reg flag_r
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r <= 1'b0;
		end else if (set_evt) begin
			flag_r <= 1'b1;
		end else if (clr) begin
			flag_r <= 1'b0;
		end
	end
endmodule

// ---- irq_status_bit.v ----
// one sticky interrupt status bit, write-one-to-clear
// assumes pclk domain inputs
`timescale 1ns/10ps
module irq_status_bit (
	input wire pclk,
	input wire presetn,
	input wire set_evt,
	input wire w1c,
	output reg stat_r
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= 1'b0;
		end else if (set_evt) begin
			stat_r <= 1'b1;
		end else if (w1c) begin
			stat_r <= 1'b0;
		end
	end
endmodule

// ---- prio_trap_ctrl.v ----
// cpu priority level, user interrupt gate and trap status flags over apb
// assumes trap inputs are one-cycle pulses in the pclk domain
// Notes on behaviour
// - a three-bit cpu priority level lives in status word bits 7..5, codes 0..7.
// - level field 7 blocks every user interrupt.
// - the effective four-bit level is the msb in core control bit 3 above the field.
// - while the msb is set all user interrupts are blocked.
// - with nesting disabled the level field ignores software writes.
// - the msb reads in core control bit 3 and software can only clear it.
// - nesting disable sits in trap control bit 15 and resets to zero.
// - divide-by-zero flag in bit 6 sets only on a math trap caused by divide by zero.
// - math trap flag in bit 4 sets on any math trap.
// - address trap flag in bit 3 sets on an address trap.
// - stack trap flag in bit 2 sets on a stack trap.
// - oscillator fail flag in bit 1 sets on an oscillator failure trap.
// - trap control bits 14..7, 5 and 0 read zero and ignore writes.
`timescale 1ns/10ps
`include "prio_trap_defines.vh"
module prio_trap_ctrl (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire math_trap,
	input wire div_zero,
	input wire addr_trap,
	input wire stack_trap,
	input wire osc_trap,
	input wire msb_set,
	output wire user_irq_enable,
	output wire [3:0] cpu_priority_level,
	output wire irq
);
	reg [2:0] level_r;
	reg msb_r;
	reg nest_r;
	reg [`EVT_W-1:0] mask_r;
	wire [`EVT_W-1:0] stat;
	wire [15:0] trap_word;
	wire [`EVT_W-1:0] evt;
	wire [`EVT_W-1:0] fclr;
	wire wr;
	wire [`EVT_W-1:0] flags;

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr = psel & penable & pwrite;

	// event order: div0, math, addr, stack, osc
	// div0 only with math trap
	assign evt[0] = math_trap & div_zero;
	assign evt[1] = math_trap;
	assign evt[2] = addr_trap;
	assign evt[3] = stack_trap;
	assign evt[4] = osc_trap;

	genvar i;
	generate
		for (i = 0; i < `EVT_W; i = i + 1) begin : g_trap
			// bit position fixed per entry, no run-time index
			localparam integer FP = (i == 0) ? `DIV0_BIT : (i == 1) ? `MATH_BIT : (i == 2) ? `ADDR_BIT :
				(i == 3) ? `STK_BIT : `OSC_BIT;
			assign fclr[i] = wr & (paddr == `OFF_TRAP_CTRL) & ~pwdata[FP];
			trap_flag_bit u_flag (
				.pclk(pclk),
				.presetn(presetn),
				.set_evt(evt[i]),
				.clr(fclr[i]),
				.flag_r(flags[i])
			);
			irq_status_bit u_stat (
				.pclk(pclk),
				.presetn(presetn),
				.set_evt(evt[i]),
				.w1c(wr & (paddr == `OFF_IRQ_STATUS) & pwdata[i]),
				.stat_r(stat[i])
			);
		end
	endgenerate

	assign trap_word = {nest_r, 8'h00, flags[0], 1'b0, flags[1], flags[2], flags[3], flags[4], 1'b0};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_r <= 3'h0;
			msb_r <= 1'b0;
			nest_r <= 1'b0;
			mask_r <= {`EVT_W{1'b0}};
		end else begin
			// locked while nesting disabled, free otherwise
			if (wr && paddr == `OFF_STATUS_WORD && !nest_r) begin
				level_r <= pwdata[`LVL_HI:`LVL_LO];
			end
			if (msb_set) begin
				msb_r <= 1'b1;
			end else if (wr && paddr == `OFF_CORE_CTRL && !pwdata[`MSB_BIT]) begin
				msb_r <= 1'b0;
			end
			if (wr && paddr == `OFF_TRAP_CTRL) begin
				nest_r <= pwdata[`NEST_BIT];
			end
			if (wr && paddr == `OFF_IRQ_MASK) begin
				mask_r <= pwdata[`EVT_W-1:0];
			end
		end
	end

	assign cpu_priority_level = {msb_r, level_r};
	assign user_irq_enable = ~msb_r & (level_r != `LVL_MAX);
	assign irq = |(stat & mask_r);

	// read data registered in setup phase; zero-wait access answers it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
			`OFF_STATUS_WORD: prdata <= {24'h000000, level_r, 5'h00};
			`OFF_CORE_CTRL: prdata <= {28'h0000000, msb_r, 3'h0};
			`OFF_TRAP_CTRL: prdata <= {16'h0000, trap_word};
			`OFF_IRQ_STATUS: prdata <= {27'h0000000, stat};
			`OFF_IRQ_MASK: prdata <= {27'h0000000, mask_r};
			default: prdata <= 32'h00000000;
			endcase
		end
	end
endmodule

// ---- prio_trap_props.sv ----
// assertions on the priority and trap block ports
// assumes bind onto prio_trap_ctrl
`timescale 1ns/10ps
module prio_trap_props(
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] prdata,
	input logic math_trap,
	input logic div_zero,
	input logic msb_set,
	input logic user_irq_enable,
	input logic [3:0] cpu_priority_level
);
	wire wa=psel&&penable&&pwrite;
	wire rd8=psel&&penable&&!pwrite&&paddr==12'h008;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_gate; user_irq_enable==(!cpu_priority_level[3]&&cpu_priority_level[2:0]!=3'h7); endproperty
	a_gate: assert property (p_gate) else $error("gate");
	property p_mset; msb_set |=> cpu_priority_level[3]; endproperty
	a_mset: assert property (p_mset) else $error("msb set");
	property p_mup; $rose(cpu_priority_level[3]) |-> $past(msb_set); endproperty
	a_mup: assert property (p_mup) else $error("msb rose");
	property p_mdn; $fell(cpu_priority_level[3]) |-> $past(wa&&paddr==12'h004); endproperty
	a_mdn: assert property (p_mdn) else $error("msb fell");
	property p_lvl; !$stable(cpu_priority_level[2:0]) |-> $past(wa&&paddr==12'h000); endproperty
	a_lvl: assert property (p_lvl) else $error("level");
	property p_rsv; rd8 |-> prdata[14:7]==8'h00&&!prdata[5]&&!prdata[0]; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved");
	property p_math; rd8&&$past(math_trap,3)&&!$past(wa&&paddr==12'h008,2) |-> prdata[4]; endproperty
	a_math: assert property (p_math) else $error("math");
	property p_div; rd8&&$past(math_trap&&div_zero,3)&&!$past(wa&&paddr==12'h008,2) |-> prdata[6]; endproperty
	a_div: assert property (p_div) else $error("div");
endmodule
bind prio_trap_ctrl prio_trap_props u_props(.*);

// ---- test_prio_trap_ctrl.sv ----
// self-checking bench for prio_trap_ctrl
// assumes apb slave and one-cycle trap pulses
`timescale 1ns/10ps
module test_prio_trap_ctrl;
	logic pclk=0,presetn=0,psel=0,penable=0,pwrite=0,msb_set=0;
	logic math_trap=0,div_zero=0,addr_trap=0,stack_trap=0,osc_trap=0;
	logic pready,pslverr,user_irq_enable,irq;
	logic [11:0] paddr=0;
	logic [31:0] pwdata=0,prdata,q,r;
	logic [3:0] cpu_priority_level;
	logic [4:0] st;
	int bad_count=0,n_checks=0;
	prio_trap_ctrl dut(.*);
	always #20 pclk=~pclk;
	task chk(input logic [31:0] g,e);
		n_checks++;
		if (g!==e) begin
			bad_count++;
			$display("Error %0t: got %h want %h",$time,g,e);
		end
	endtask
	task xf(input logic w,input logic [11:0] a,input logic [31:0] d);
		psel<=1;
		pwrite<=w;
		paddr<=a;
		pwdata<=d;
		@(posedge pclk) penable<=1;
		do @(posedge pclk); while (pready!==1'b1);
		q=prdata;
		chk(pslverr,1'b0);
		psel<=0;
		penable<=0;
		@(posedge pclk);
	endtask
	task pulse(input logic [5:0] v);
		{msb_set,osc_trap,stack_trap,addr_trap,div_zero,math_trap}<=v;
		@(posedge pclk);
		{msb_set,osc_trap,stack_trap,addr_trap,div_zero,math_trap}<=6'h00;
		@(posedge pclk);
	endtask
	// flag word from a random trap pattern
	function logic [31:0] tw(input logic [31:0] r);
		return {25'h0,r[5]&r[6],1'b0,r[5],r[7],r[8],r[9],1'b0};
	endfunction
	task summarize;
		if (bad_count==0&&n_checks>0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		summarize;
	end
	initial begin
		r=$urandom(39711);
		repeat (4) @(posedge pclk);
		presetn<=1;
		@(posedge pclk);
		xf(1,12'h014,32'hffffffff);
		for (int a=0;a<24;a+=4) begin
			xf(0,a[11:0],32'h0);
			chk(q,32'h0);
		end
		for (int l=0;l<8;l++) begin
			r=$urandom;
			xf(1,12'h000,{r[31:8],l[2:0],r[4:0]});
			xf(0,12'h000,32'h0);
			chk(q&32'he0,{l[2:0],5'h0});
			chk(user_irq_enable,l!=7);
		end
		pulse(6'h20);
		chk(cpu_priority_level,4'hf);
		xf(1,12'h000,32'h0);
		chk(user_irq_enable,1'b0);
		xf(0,12'h004,32'h0);
		chk(q,32'h8);
		xf(1,12'h004,32'h0);
		xf(1,12'h004,32'h8);
		chk(cpu_priority_level,4'h0);
		xf(1,12'h008,32'hffff);
		xf(0,12'h008,32'h0);
		chk(q,32'h8000);
		xf(1,12'h000,32'h60);
		chk(cpu_priority_level,4'h0);
		xf(1,12'h008,32'h0);
		xf(1,12'h000,32'h60);
		chk(cpu_priority_level,4'h3);
		repeat (10) begin
			r=$urandom;
			st={r[9:7],r[5],r[5]&r[6]};
			xf(1,12'h010,{27'h0,r[4:0]});
			pulse({1'b0,r[9:5]});
			xf(0,12'h008,32'h0);
			chk(q,tw(r));
			chk(irq,|(st&r[4:0]));
			xf(0,12'h00c,32'h0);
			chk(q,{27'h0,st});
			xf(1,12'h008,32'h7fa1);
			xf(0,12'h008,32'h0);
			chk(q,32'h0);
			xf(1,12'h00c,32'h1f);
			chk(irq,1'b0);
		end
		// clear write and math trap on the same edge
		psel<=1;
		pwrite<=1;
		paddr<=12'h008;
		pwdata<=32'h0;
		@(posedge pclk);
		penable<=1;
		math_trap<=1;
		do @(posedge pclk); while (pready!==1'b1);
		psel<=0;
		penable<=0;
		math_trap<=0;
		@(posedge pclk);
		xf(0,12'h008,32'h0);
		chk(q,32'h10);
		summarize;
	end
endmodule
